// File: test/dqt_ctrl_model.sv
// Memory controller model: link clock and command issue
`timescale 1ns/1ns
module dqt_ctrl_model (
  output logic LINK_CK,
  output logic MPC_VALID,
  output logic [6:0] MPC_OP,
  output logic CAS2_VALID,
  output logic MRW_VALID,
  output logic MRR_VALID,
  output logic [dqt_pkg::MR_AW-1:0] MR_ADDR,
  output logic [dqt_pkg::MR_DW-1:0] MR_WDATA,
  input wire logic [dqt_pkg::MR_DW-1:0] MRR_DATA,
  input wire logic MRR_DONE
);
  import dqt_pkg::*;
  ////////////////////////////////////////////////////////////
  // Device clock runs free, offset from the core clock
  initial begin
    LINK_CK = 1'b0;
    #37;
    forever #80 LINK_CK = ~LINK_CK;
  end
  // Idle command bus at time zero
  initial begin
    {MPC_VALID, MPC_OP, CAS2_VALID, MRW_VALID, MRR_VALID, MR_ADDR, MR_WDATA} = '0;
  end
  ////////////////////////////////////////////////////////////
  // One link edge, then the drive delay
  task automatic idle();
    @(posedge LINK_CK);
    #1;
  endtask
  // Mode register write
  task automatic mrw(input logic [5:0] a, input logic [7:0] d);
    MR_ADDR = a;
    MR_WDATA = d;
    MRW_VALID = 1'b1;
    idle();
    MRW_VALID = 1'b0;
    idle();
  endtask
  // Mode register read, bounded wait for the done pulse
  task automatic mrr(input logic [5:0] a, output logic [7:0] d, output bit ok);
    MR_ADDR = a;
    MRR_VALID = 1'b1;
    idle();
    MRR_VALID = 1'b0;
    ok = 1'b0;
    d = '0;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (MRR_DONE === 1'b1) begin
        ok = 1'b1;
        d = MRR_DATA;
      end else begin
        idle();
      end
    end
    idle();
  endtask
  // Single multi-purpose command
  task automatic mpc(input logic [6:0] op);
    MPC_OP = op;
    MPC_VALID = 1'b1;
    idle();
    MPC_VALID = 1'b0;
    idle();
  endtask
  // Calibration read: MPC, then an all-low second phase at once
  task automatic cal();
    MPC_OP = MPC_RD_CAL;
    MPC_VALID = 1'b1;
    idle();
    MPC_VALID = 1'b0;
    CAS2_VALID = 1'b1;
    idle();
    CAS2_VALID = 1'b0;
    idle();
  endtask
  // Oscillator run and readout of both result bytes
  task automatic osc_run(input int n, input bit auto_stop, output logic [15:0] cnt, output bit ok);
    logic [7:0] lo, hi;
    bit k1, k2;
    mpc(MPC_OSC_START);
    repeat (n) idle();
    if (!auto_stop) mpc(MPC_OSC_STOP);
    repeat (RDOUT_NCK) idle();
    mrr(MRA_OSC_LO, lo, k1);
    mrr(MRA_OSC_HI, hi, k2);
    cnt = {hi, lo};
    ok = k1 & k2;
  endtask
endmodule

// File: test/dqt_top_tb_top.sv
// Testbench for the strobe oscillator and read-preamble training block
`timescale 1ns/1ns
module dqt_top_tb_top;
  import dqt_pkg::*;
  localparam int LAT = 7;
  localparam logic [7:0] PAT1 = 8'ha5;
  localparam logic [7:0] PAT2 = 8'h3c;
  localparam logic [15:0] INV = 16'h810f;
  logic CLOCK, SRST, LINK_CK, MPC_VALID, CAS2_VALID, MRW_VALID, MRR_VALID, MRR_DONE;
  logic DQ_OE_N, MASK_INV_OE_N, DQS_T, DQS_C, DQS_OE_N;
  logic [6:0] MPC_OP;
  logic [5:0] MR_ADDR;
  logic [7:0] MR_WDATA, MRR_DATA;
  logic [15:0] DQ;
  logic [1:0] MASK_INV;
  int error_cnt = 0;
  int total_checks = 0;
  ////////////////////////////////////////////////////////////
  // Core clock and instances
  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end
  dqt_ctrl_model i_ctrl (.LINK_CK(LINK_CK), .MPC_VALID(MPC_VALID), .MPC_OP(MPC_OP), .CAS2_VALID(CAS2_VALID),
    .MRW_VALID(MRW_VALID), .MRR_VALID(MRR_VALID), .MR_ADDR(MR_ADDR), .MR_WDATA(MR_WDATA),
    .MRR_DATA(MRR_DATA), .MRR_DONE(MRR_DONE));
  dqt_top #(.READ_LATENCY(6), .STROBE_ACCESS(1)) i_dut (.CLOCK(CLOCK), .SRST(SRST), .LINK_CK(LINK_CK),
    .MPC_VALID(MPC_VALID), .MPC_OP(MPC_OP), .CAS2_VALID(CAS2_VALID), .MRW_VALID(MRW_VALID),
    .MRR_VALID(MRR_VALID), .MR_ADDR(MR_ADDR), .MR_WDATA(MR_WDATA), .MRR_DATA(MRR_DATA), .MRR_DONE(MRR_DONE),
    .DQ(DQ), .DQ_OE_N(DQ_OE_N), .MASK_INV(MASK_INV), .MASK_INV_OE_N(MASK_INV_OE_N), .DQS_T(DQS_T),
    .DQS_C(DQS_C), .DQS_OE_N(DQS_OE_N));
  ////////////////////////////////////////////////////////////
  // Pin views and expected beats
  function automatic logic [4:0] st();
    return {DQ_OE_N, MASK_INV_OE_N, DQS_OE_N, DQS_T, DQS_C};
  endfunction
  function automatic logic [22:0] pins();
    return {st(), MASK_INV, DQ};
  endfunction
  function automatic logic [22:0] beat(input logic [4:0] b);
    logic raw;
    raw = (b < 8) ? PAT1[b] : PAT2[b-8];
    return {3'b000, ~b[0], b[0], {2{raw}}, {16{raw}} ^ INV};
  endfunction
  ////////////////////////////////////////////////////////////
  // Compare tasks and verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_in(input logic [15:0] got, input int lo, input int hi, input string what);
    total_checks++;
    if ($isunknown(got) || got < lo || got > hi) begin
      error_cnt++;
      $display("ERROR at %0t ns: %s count %0d outside %0d..%0d", $time, what, got, lo, hi);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Bounded wait ran out: count it and stop
  task automatic ok_or_stop(input bit ok);
    if (!ok) begin
      error_cnt++;
      $display("ERROR at %0t ns: read done never came", $time);
      test_done();
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    bit ok;
    i_ctrl.mrr(a, d, ok);
    ok_or_stop(ok);
    chk(d, exp, what);
  endtask
  // Oscillator run with range check of the count
  task automatic osc(input int rt, input int n, input int lo, input int hi, input string what);
    logic [15:0] c;
    bit ok;
    i_ctrl.mrw(MRA_RUNTIME, rt[7:0]);
    i_ctrl.osc_run(n, rt != 0, c, ok);
    ok_or_stop(ok);
    chk_in(c, lo, hi, what);
  endtask
  ////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_reset();
    chk(st(), 5'b11101, "pins at reset");
    rd(MRA_OSC_LO, 8'h00, "low byte at reset");
    rd(MRA_OSC_HI, 8'h00, "high byte at reset");
    rd(6'h3f, 8'h00, "unmapped read");
    $display("test reset done");
  endtask
  task automatic test_osc();
    osc(0, 8, 196, 204, "stop by command");
    i_ctrl.mrw(MRA_OSC_HI, 8'h5a);
    rd(MRA_OSC_HI, 8'h00, "result is read only");
    osc(0, 3, 96, 104, "second run overwrites");
    osc(5, 6, 96, 104, "stop by run timer");
    // All ones read back means the counter saturated at its maximum, the count is kept
    osc(0, 3300, 65535, 65535, "saturated");
    $display("test oscillator done");
  endtask
  // Calibration reads while training is on, then one with training off
  task automatic test_train();
    i_ctrl.mrw(MRA_PAT1, PAT1);
    i_ctrl.mrw(MRA_PAT2, PAT2);
    i_ctrl.mrw(MRA_INV_LO, INV[7:0]);
    i_ctrl.mrw(MRA_INV_HI, INV[15:8]);
    i_ctrl.mrw(MRA_TRAIN, 8'h02);
    repeat (DRV_NCK - 1) i_ctrl.idle();
    chk(st(), 5'b11001, "strobe parked");
    i_ctrl.cal();
    fork
      begin
        repeat (13) i_ctrl.idle();
        i_ctrl.cal();
      end
      begin
        repeat (LAT - 1) i_ctrl.idle();
        chk(st(), 5'b11001, "no preamble");
        for (int b = 0; b < 2 * BURST_BEATS; b++) begin
          i_ctrl.idle();
          chk(pins(), beat(b[4:0] & 5'h0f), "burst beat");
        end
      end
    join
    i_ctrl.idle();
    chk(st(), 5'b11001, "after burst");
    i_ctrl.mrw(MRA_TRAIN, 8'h00);
    repeat (DRV_NCK - 1) i_ctrl.idle();
    chk(st(), 5'b11101, "training left");
    i_ctrl.cal();
    repeat (LAT + 2) begin
      i_ctrl.idle();
      chk(DQ_OE_N, 1'b1, "no burst when off");
    end
    $display("test training done");
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    SRST = 1'b1;
    repeat (8) @(posedge CLOCK);
    repeat (5) @(posedge LINK_CK);
    @(posedge CLOCK);
    #1;
    SRST = 1'b0;
    repeat (4) i_ctrl.idle();
    test_reset();
    test_osc();
    test_train();
    test_done();
  end
endmodule

// File: verilog/dqt_pkg.sv
// Shared constants for the strobe oscillator and read-preamble training block
package dqt_pkg;
  // Counter, mode register and pin widths, burst length
  localparam int OSC_W = 16;
  localparam int MR_AW = 6;
  localparam int MR_DW = 8;
  localparam int DQ_W = 16;
  localparam int MASK_INV_W = 2;
  localparam int BURST_BEATS = 16;
  // Mode register addresses
  localparam logic [5:0] MRA_TRAIN = 6'h0d;
  localparam logic [5:0] MRA_INV_LO = 6'h0f;
  localparam logic [5:0] MRA_OSC_LO = 6'h12;
  localparam logic [5:0] MRA_OSC_HI = 6'h13;
  localparam logic [5:0] MRA_INV_HI = 6'h14;
  localparam logic [5:0] MRA_RUNTIME = 6'h17;
  localparam logic [5:0] MRA_PAT1 = 6'h20;
  localparam logic [5:0] MRA_PAT2 = 6'h28;
  // Field position of the training enable
  localparam int TRAIN_BIT = 1;
  // Reset values and counter maximum
  localparam logic [7:0] MR_RESET = 8'h00;
  localparam logic [15:0] OSC_RESET = 16'h0000;
  localparam logic [15:0] OSC_MAX = 16'hffff;
  // Multi-purpose command operand codes
  localparam logic [6:0] MPC_OSC_START = 7'h4b;
  localparam logic [6:0] MPC_OSC_STOP = 7'h4d;
  localparam logic [6:0] MPC_RD_CAL = 7'h43;
  // Timing
  localparam int CLK_NS = 8;
  localparam int DRV_NS = 20;
  localparam int DRV_NCK = 12;
  localparam int DRV_CYC = (DRV_NCK > (DRV_NS + CLK_NS - 1) / CLK_NS) ? DRV_NCK : (DRV_NS + CLK_NS - 1) / CLK_NS;
  localparam int RDOUT_NS = 40;
  localparam int RDOUT_NCK = 8;
  localparam int RDOUT_CYC = (RDOUT_NCK > (RDOUT_NS + CLK_NS - 1) / CLK_NS) ? RDOUT_NCK : (RDOUT_NS + CLK_NS - 1) / CLK_NS;
  // Oscillator run state seen from the link
  typedef enum logic {OSC_IDLE = 1'b0, OSC_RUN = 1'b1} dqt_osc_e;
endpackage

// File: verilog/dqt_top.sv
// Strobe interval oscillator and read-preamble training logic
// Behaviour
// - Oscillator result low byte goes to one register, high byte to the other.
// - With zero run time, a stop-oscillator command overwrites both result registers.
// - The oscillator counter saturates at its maximum instead of wrapping.
// - Zero run time means stop by command; nonzero stops after programmed count.
// - Training enable drives true strobe low, complement high, until calibration read.
// - During training the normal read strobe preamble is omitted.
// - Calibration read drives strobes and data like normal read after latency.
// - Data lines before first calibration read may be driven or not.
// - Each burst sends first pattern byte then second on every data pin.
// - Pins whose invert-mask bit is one get the pattern inverted.
// - Pattern also driven on mask/inversion pins, never bus-inverted.
// - Training ends within strobe-driven delay after enable written zero.
// - Strobes driven within max of 12 clocks and 20 ns of the write.
// - Calibration bursts are sixteen beats long unless a new launch restarts the burst at beat zero.
// - Start, stop and calibration use their fixed multi-purpose operand codes.
`timescale 1ns/1ns
module dqt_top #(
  parameter int READ_LATENCY = 6,
  parameter int STROBE_ACCESS = 1
) (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic LINK_CK,
  input wire logic MPC_VALID,
  input wire logic [6:0] MPC_OP,
  input wire logic CAS2_VALID,
  input wire logic MRW_VALID,
  input wire logic MRR_VALID,
  input wire logic [dqt_pkg::MR_AW-1:0] MR_ADDR,
  input wire logic [dqt_pkg::MR_DW-1:0] MR_WDATA,
  output logic [dqt_pkg::MR_DW-1:0] MRR_DATA,
  output logic MRR_DONE,
  output logic [dqt_pkg::DQ_W-1:0] DQ,
  output logic DQ_OE_N,
  output logic [dqt_pkg::MASK_INV_W-1:0] MASK_INV,
  output logic MASK_INV_OE_N,
  output logic DQS_T,
  output logic DQS_C,
  output logic DQS_OE_N
);
  import dqt_pkg::*;
  localparam int LAT = READ_LATENCY + STROBE_ACCESS;

  ////////////////////////////////////////////////////////////////////////////
  // Link-side reset and command decode
  logic lrst_meta, lrst;
  logic [7:0] train_mr, runtime, pat1, pat2, inv_lo, inv_hi, osc_lo, osc_hi;
  wire train = train_mr[TRAIN_BIT];
  wire [15:0] inv = {inv_hi, inv_lo};
  wire cmd_start = MPC_VALID && MPC_OP == MPC_OSC_START;
  wire cmd_stop = MPC_VALID && MPC_OP == MPC_OSC_STOP;
  wire cmd_cal = MPC_VALID && MPC_OP == MPC_RD_CAL;

  // Reset brought into the link domain
  always_ff @(posedge LINK_CK) begin
    lrst_meta <= SRST;
    lrst <= lrst_meta;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers written and read over the command bus
  wire wr_train = MRW_VALID && MR_ADDR == MRA_TRAIN;
  wire wr_rt = MRW_VALID && MR_ADDR == MRA_RUNTIME;
  wire wr_p1 = MRW_VALID && MR_ADDR == MRA_PAT1;
  wire wr_p2 = MRW_VALID && MR_ADDR == MRA_PAT2;
  wire wr_il = MRW_VALID && MR_ADDR == MRA_INV_LO;
  wire wr_ih = MRW_VALID && MR_ADDR == MRA_INV_HI;
  logic [7:0] next_rdata;
  always_comb begin
    if (MR_ADDR == MRA_OSC_LO) begin
      next_rdata = osc_lo;
    end else if (MR_ADDR == MRA_OSC_HI) begin
      next_rdata = osc_hi;
    end else if (MR_ADDR == MRA_TRAIN) begin
      next_rdata = train_mr;
    end else if (MR_ADDR == MRA_RUNTIME) begin
      next_rdata = runtime;
    end else if (MR_ADDR == MRA_PAT1) begin
      next_rdata = pat1;
    end else if (MR_ADDR == MRA_PAT2) begin
      next_rdata = pat2;
    end else if (MR_ADDR == MRA_INV_LO) begin
      next_rdata = inv_lo;
    end else if (MR_ADDR == MRA_INV_HI) begin
      next_rdata = inv_hi;
    end else begin
      next_rdata = MR_RESET;
    end
  end

  // Writable registers; training enable reacts on the next edge
  always_ff @(posedge LINK_CK) begin
    if (lrst) begin
      train_mr <= MR_RESET;
      runtime <= MR_RESET;
      pat1 <= MR_RESET;
      pat2 <= MR_RESET;
      inv_lo <= MR_RESET;
      inv_hi <= MR_RESET;
    end else begin
      if (wr_train) train_mr <= MR_WDATA;
      if (wr_rt) runtime <= MR_WDATA;
      if (wr_p1) pat1 <= MR_WDATA;
      if (wr_p2) pat2 <= MR_WDATA;
      if (wr_il) inv_lo <= MR_WDATA;
      if (wr_ih) inv_hi <= MR_WDATA;
    end
  end

  // Read answer one edge after the request
  always_ff @(posedge LINK_CK) begin
    if (lrst) begin
      MRR_DATA <= MR_RESET;
      MRR_DONE <= 1'b0;
    end else begin
      MRR_DATA <= MRR_VALID ? next_rdata : MRR_DATA;
      MRR_DONE <= MRR_VALID;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator control and interval timer in the link domain
  dqt_osc_e osc_st;
  logic [7:0] timer;
  logic start_tgl, stop_tgl;
  wire auto_end = osc_st == OSC_RUN && runtime != MR_RESET && timer == 8'h01;
  wire stop_now = osc_st == OSC_RUN && ((cmd_stop && runtime == MR_RESET) || auto_end);
  always_ff @(posedge LINK_CK) begin
    if (lrst) begin
      osc_st <= OSC_IDLE;
      timer <= MR_RESET;
      start_tgl <= 1'b0;
      stop_tgl <= 1'b0;
    end else begin
      case (osc_st)
        OSC_IDLE: begin
          if (cmd_start) begin
            osc_st <= OSC_RUN;
            timer <= runtime;
            start_tgl <= ~start_tgl;
          end
        end
        OSC_RUN: begin
          timer <= timer - 8'h01;
          if (stop_now) begin
            osc_st <= OSC_IDLE;
            stop_tgl <= ~stop_tgl;
          end
        end
        default: osc_st <= OSC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interval counter on the core clock
  logic [2:0] st_sync, sp_sync;
  logic running, done_tgl;
  logic [15:0] osc_count, result;
  wire start_evt = st_sync[2] ^ st_sync[1];
  wire stop_evt = sp_sync[2] ^ sp_sync[1];
  wire count_max = osc_count == OSC_MAX;
  always_ff @(posedge CLOCK) begin
    st_sync <= {st_sync[1:0], start_tgl};
    sp_sync <= {sp_sync[1:0], stop_tgl};
  end

  // Counting saturates; stop captures the count and flags the link
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      running <= 1'b0;
      osc_count <= OSC_RESET;
      result <= OSC_RESET;
      done_tgl <= 1'b0;
    end else if (stop_evt) begin
      running <= 1'b0;
      result <= osc_count;
      done_tgl <= ~done_tgl;
    end else if (start_evt) begin
      running <= 1'b1;
      osc_count <= OSC_RESET;
    end else if (running && !count_max) begin
      osc_count <= osc_count + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result returned to the link registers
  logic [2:0] dn_sync;
  wire done_evt = dn_sync[2] ^ dn_sync[1];
  always_ff @(posedge LINK_CK) begin
    dn_sync <= {dn_sync[1:0], done_tgl};
  end
  always_ff @(posedge LINK_CK) begin
    if (lrst) begin
      osc_lo <= MR_RESET;
      osc_hi <= MR_RESET;
    end else if (done_evt) begin
      osc_lo <= result[7:0];
      osc_hi <= result[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration read launch and latency line
  logic cal_armed, burst_on;
  logic [LAT-1:0] lat_line;
  logic [4:0] beat;
  wire launch = cal_armed && CAS2_VALID && train;
  always_ff @(posedge LINK_CK) begin
    if (lrst) begin
      cal_armed <= 1'b0;
      lat_line <= '0;
    end else begin
      cal_armed <= cmd_cal;
      lat_line <= {lat_line[LAT-2:0], launch};
    end
  end

  // Beat counter; a new launch restarts a full burst
  wire burst_go = lat_line[LAT-1];
  always_ff @(posedge LINK_CK) begin
    if (lrst) begin
      burst_on <= 1'b0;
      beat <= 5'h00;
    end else if (burst_go) begin
      burst_on <= 1'b1;
      beat <= 5'h00;
    end else if (burst_on) begin
      burst_on <= beat != 5'h0f;
      beat <= beat + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive
  wire pat_bit = beat[3] ? pat2[beat[2:0]] : pat1[beat[2:0]];
  wire [15:0] next_dq = {16{pat_bit}} ^ inv;
  wire next_dqs_oe_n = !(burst_on || train);
  wire next_dqs_t = burst_on ? !beat[0] : 1'b0;
  wire next_dqs_c = burst_on ? beat[0] : 1'b1;
  always_ff @(posedge LINK_CK) begin
    if (lrst) begin
      DQ <= '0;
      DQ_OE_N <= 1'b1;
      MASK_INV <= '0;
      MASK_INV_OE_N <= 1'b1;
      DQS_T <= 1'b0;
      DQS_C <= 1'b1;
      DQS_OE_N <= 1'b1;
    end else begin
      DQ <= next_dq;
      DQ_OE_N <= !burst_on;
      MASK_INV <= {2{pat_bit}};
      MASK_INV_OE_N <= !burst_on;
      DQS_T <= next_dqs_t;
      DQS_C <= next_dqs_c;
      DQS_OE_N <= next_dqs_oe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_CNT_SAT: assert property (@(posedge CLOCK) disable iff (SRST)
    running && count_max && !stop_evt && !start_evt |=> osc_count == OSC_MAX)
    else $error("counter wrapped");
  AST_RES_LOAD: assert property (@(posedge LINK_CK) disable iff (lrst)
    done_evt |=> osc_lo == result[7:0] && osc_hi == result[15:8])
    else $error("result not stored");
  AST_STOP_CAP: assert property (@(posedge CLOCK) disable iff (SRST)
    stop_evt |=> result == $past(osc_count) && !running)
    else $error("stop did not capture count");
  AST_AUTO_STOP: assert property (@(posedge LINK_CK) disable iff (lrst)
    osc_st == OSC_RUN && runtime != MR_RESET && timer == 8'h01 |=> osc_st == OSC_IDLE && $changed(stop_tgl))
    else $error("timer did not stop oscillator");
  AST_TRAIN_DQS: assert property (@(posedge LINK_CK) disable iff (lrst)
    train && !burst_on |=> !DQS_OE_N && !DQS_T && DQS_C)
    else $error("strobe not parked in training");
  AST_DRV_DELAY: assert property (@(posedge LINK_CK) disable iff (lrst)
    wr_train && MR_WDATA[TRAIN_BIT] |-> ##2 !DQS_OE_N)
    else $error("strobe drive late");
  AST_EXIT: assert property (@(posedge LINK_CK) disable iff (lrst)
    $fell(train) && !burst_on && !burst_go |=> DQS_OE_N)
    else $error("training not left");
  AST_NO_PRE: assert property (@(posedge LINK_CK) disable iff (lrst)
    burst_go && train |=> !DQS_T && DQS_C ##1 DQS_T && !DQS_OE_N)
    else $error("preamble driven");
  AST_BURST_LEN: assert property (@(posedge LINK_CK) disable iff (lrst)
    $rose(burst_on) |-> burst_on[*8] ##1 burst_on[*8])
    else $error("burst shorter than sixteen beats");
  AST_PATTERN: assert property (@(posedge LINK_CK) disable iff (lrst)
    burst_on && beat == 5'h08 |=> DQ == ({16{pat2[0]}} ^ inv) && MASK_INV == {2{pat2[0]}})
    else $error("wrong pattern on data pins");
  AST_MASK_INV: assert property (@(posedge LINK_CK) disable iff (lrst)
    !MASK_INV_OE_N |-> DQ[0] == (MASK_INV[0] ^ inv[0]) && MASK_INV[1] == MASK_INV[0])
    else $error("mask pins inverted");
  AST_DQ_IDLE: assert property (@(posedge LINK_CK) disable iff (lrst)
    !burst_on |=> DQ_OE_N)
    else $error("data driven outside burst");
  COV_OSC_CMD: cover property (@(posedge LINK_CK) disable iff (lrst) cmd_stop && osc_st == OSC_RUN);
  COV_OSC_AUTO: cover property (@(posedge LINK_CK) disable iff (lrst) auto_end);
  COV_CAL: cover property (@(posedge LINK_CK) disable iff (lrst) $rose(burst_on) && train);
endmodule
